// ### core/gpw_timers.sv
// one-shot timer and watchdog timer with their register file
`timescale 1ns/100ps
`include "gpw_regs.svh"

// What this block does
// - two independent timers, one-shot and watchdog, each with an 8-bit counter
// - one-shot ticks at 32.768 kHz, 1024 Hz, 1 Hz or one minute
// - watchdog ticks at 8 Hz, 1 Hz, 0.5 Hz or one minute
// - one-shot rate chosen by tick select bits 1:0
// - watchdog rate chosen by tick select bits 5:4
// - writing one to one-shot run bit starts counting up to its limit
// - reaching the limit sets the one-shot expired flag, status bit 0
// - one-shot expiry interrupts only when irq enable bit 0 is set
// - expired flags stay set until written with one; zero leaves them
// - after one-shot expiry counter stops, clears, run bit clears, settings kept
// - writing zero to one-shot run bit stops and clears the counter
// - writing one to watchdog run bit starts counting up to its limit
// - watchdog expiry sets status bit 4, interrupts when enable bit 4 set
// - after watchdog expiry counter stops, clears, and its run bit clears
// - kick bit 4 clears the watchdog count; counting continues only if run bit 0 is written one with it
// - kick acts only when written one and always reads zero
// - global gate bit zero by default freezes the timers, settings kept
// - both limit registers are 8-bit read-write, reset to all ones
module gpw_timers
  import gpw_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic rtc_tick_32k,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic timer_irq,
  output logic oneshot_running,
  output logic dog_running
);

  // ==========================================================
  // counter step shared by both timers
  function automatic gpw_cnt_type cnt_step(
    input gpw_cnt_type cur,
    input logic tick,
    input gpw_byte_type limit,
    input logic gate,
    input logic ctl_wr,
    input logic run_bit,
    input logic kick
  );
    gpw_cnt_type nxt;
    nxt = cur;
    nxt.expired = 1'b0;
    // no expiry while the timer clock is gated off
    if (cur.run && gate && (cur.count == limit)) begin
      // expiry beats a same-cycle write, so a timeout is never swallowed
      nxt.run = 1'b0;
      nxt.count = `GPW_COUNT_ZERO;
      nxt.expired = 1'b1;
    end else begin
      if (cur.run && tick) begin
        nxt.count = 8'(cur.count + 8'h01);
      end
      if (kick) begin
        nxt.count = `GPW_COUNT_ZERO;
      end
      if (ctl_wr) begin
        nxt.run = run_bit;
        if (!run_bit) begin
          nxt.count = `GPW_COUNT_ZERO;
        end
      end
    end
    return nxt;
  endfunction : cnt_step

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input gpw_byte_type target);
    return a == ADDR_W'(target);
  endfunction : addr_is

  // ==========================================================
  // timebase
  gpw_tick_if tk ();

  gpw_tickgen u_tickgen (
    .clk(clk),
    .rst(rst),
    .rtc_tick_32k(rtc_tick_32k),
    .tk(tk)
  );

  // ==========================================================
  // settings
  logic gate_q, gate_d;
  gpw_sel_type os_sel_q, os_sel_d;
  gpw_sel_type dog_sel_q, dog_sel_d;
  gpw_byte_type os_limit_q, os_limit_d;
  gpw_byte_type dog_limit_q, dog_limit_d;
  logic os_ien_q, os_ien_d;
  logic dog_ien_q, dog_ien_d;

  always_comb begin
    gate_d = gate_q;
    os_sel_d = os_sel_q;
    dog_sel_d = dog_sel_q;
    os_limit_d = os_limit_q;
    dog_limit_d = dog_limit_q;
    os_ien_d = os_ien_q;
    dog_ien_d = dog_ien_q;
    if (reg_wr) begin
      if (addr_is(reg_addr, `GPW_ADDR_POWER)) begin
        gate_d = reg_wdata[`GPW_GATE_BIT];
      end
      if (addr_is(reg_addr, `GPW_ADDR_TICKSEL)) begin
        os_sel_d = reg_wdata[`GPW_OS_SEL_LO +: 2];
        dog_sel_d = reg_wdata[`GPW_DOG_SEL_LO +: 2];
      end
      if (addr_is(reg_addr, `GPW_ADDR_OS_LIMIT)) begin
        os_limit_d = reg_wdata;
      end
      if (addr_is(reg_addr, `GPW_ADDR_DOG_LIMIT)) begin
        dog_limit_d = reg_wdata;
      end
      if (addr_is(reg_addr, `GPW_ADDR_IRQ_EN)) begin
        os_ien_d = reg_wdata[`GPW_OS_IRQ_BIT];
        dog_ien_d = reg_wdata[`GPW_DOG_IRQ_BIT];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gate_q <= 1'b0;
      os_sel_q <= `GPW_SEL_RESET;
      dog_sel_q <= `GPW_SEL_RESET;
      os_limit_q <= `GPW_LIMIT_RESET;
      dog_limit_q <= `GPW_LIMIT_RESET;
      os_ien_q <= 1'b0;
      dog_ien_q <= 1'b0;
    end else begin
      gate_q <= gate_d;
      os_sel_q <= os_sel_d;
      dog_sel_q <= dog_sel_d;
      os_limit_q <= os_limit_d;
      dog_limit_q <= dog_limit_d;
      os_ien_q <= os_ien_d;
      dog_ien_q <= dog_ien_d;
    end
  end

  assign tk.gate_on = gate_q;
  assign tk.os_sel = os_sel_q;
  assign tk.dog_sel = dog_sel_q;

  // ==========================================================
  // counters
  gpw_cnt_type os_q, os_d;
  gpw_cnt_type dog_q, dog_d;
  logic os_ctl_wr;
  logic dog_ctl_wr;
  logic dog_kick;

  always_comb begin
    os_ctl_wr = reg_wr && addr_is(reg_addr, `GPW_ADDR_OS_CTL);
    // gated ticks never arrive, so counts freeze rather than clear
    os_d = cnt_step(os_q, tk.os_tick, os_limit_q, gate_q, os_ctl_wr, reg_wdata[`GPW_RUN_BIT], 1'b0);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      os_q <= '0;
    end else begin
      os_q <= os_d;
    end
  end

  always_comb begin
    dog_ctl_wr = reg_wr && addr_is(reg_addr, `GPW_ADDR_DOG_CTL);
    // kick is a write-side action only, nothing stores it
    dog_kick = dog_ctl_wr && reg_wdata[`GPW_KICK_BIT];
    dog_d = cnt_step(dog_q, tk.dog_tick, dog_limit_q, gate_q, dog_ctl_wr, reg_wdata[`GPW_RUN_BIT], dog_kick);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dog_q <= '0;
    end else begin
      dog_q <= dog_d;
    end
  end

  // ==========================================================
  // expired flags and interrupt
  logic os_flag_q, os_flag_d;
  logic dog_flag_q, dog_flag_d;
  logic irq_q, irq_d;
  logic status_wr;

  assign status_wr = reg_wr && addr_is(reg_addr, `GPW_ADDR_STATUS);

  always_comb begin
    os_flag_d = os_flag_q;
    if (status_wr && reg_wdata[`GPW_OS_FLAG_BIT]) begin
      os_flag_d = 1'b0;
    end
    // set after clear: a timeout in the clear cycle survives
    if (os_d.expired) begin
      os_flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      os_flag_q <= 1'b0;
    end else begin
      os_flag_q <= os_flag_d;
    end
  end

  always_comb begin
    dog_flag_d = dog_flag_q;
    if (status_wr && reg_wdata[`GPW_DOG_FLAG_BIT]) begin
      dog_flag_d = 1'b0;
    end
    if (dog_d.expired) begin
      dog_flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dog_flag_q <= 1'b0;
    end else begin
      dog_flag_q <= dog_flag_d;
    end
  end

  always_comb begin
    irq_d = (os_flag_d && os_ien_d) || (dog_flag_d && dog_ien_d);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // ==========================================================
  // readback
  gpw_byte_type rdata_q, rdata_d;

  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      rdata_d = `GPW_BYTE_ZERO;
      if (addr_is(reg_addr, `GPW_ADDR_POWER)) begin
        rdata_d[`GPW_GATE_BIT] = gate_q;
      end
      if (addr_is(reg_addr, `GPW_ADDR_DOG_CTL)) begin
        // kick bit left at zero
        rdata_d[`GPW_RUN_BIT] = dog_q.run;
      end
      if (addr_is(reg_addr, `GPW_ADDR_OS_CTL)) begin
        rdata_d[`GPW_RUN_BIT] = os_q.run;
      end
      if (addr_is(reg_addr, `GPW_ADDR_STATUS)) begin
        rdata_d[`GPW_OS_FLAG_BIT] = os_flag_q;
        rdata_d[`GPW_DOG_FLAG_BIT] = dog_flag_q;
      end
      if (addr_is(reg_addr, `GPW_ADDR_OS_LIMIT)) begin
        rdata_d = os_limit_q;
      end
      if (addr_is(reg_addr, `GPW_ADDR_DOG_LIMIT)) begin
        rdata_d = dog_limit_q;
      end
      if (addr_is(reg_addr, `GPW_ADDR_TICKSEL)) begin
        rdata_d[`GPW_OS_SEL_LO +: 2] = os_sel_q;
        rdata_d[`GPW_DOG_SEL_LO +: 2] = dog_sel_q;
      end
      if (addr_is(reg_addr, `GPW_ADDR_IRQ_EN)) begin
        rdata_d[`GPW_OS_IRQ_BIT] = os_ien_q;
        rdata_d[`GPW_DOG_IRQ_BIT] = dog_ien_q;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= `GPW_BYTE_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign timer_irq = irq_q;
  assign oneshot_running = os_q.run;
  assign dog_running = dog_q.run;

endmodule : gpw_timers

// ### core/gpw_regs.svh
// register map, bit positions, reset values and divider masks of the timer block
`ifndef GPW_REGS_SVH
`define GPW_REGS_SVH

// ==========================================================
// register byte addresses
`define GPW_ADDR_POWER 8'h3a
`define GPW_ADDR_DOG_CTL 8'ha0
`define GPW_ADDR_OS_CTL 8'ha1
`define GPW_ADDR_STATUS 8'ha2
`define GPW_ADDR_OS_LIMIT 8'ha3
`define GPW_ADDR_DOG_LIMIT 8'ha4
`define GPW_ADDR_TICKSEL 8'ha5
`define GPW_ADDR_IRQ_EN 8'ha6

// ==========================================================
// bit positions
`define GPW_GATE_BIT 0
`define GPW_RUN_BIT 0
`define GPW_KICK_BIT 4
`define GPW_OS_FLAG_BIT 0
`define GPW_DOG_FLAG_BIT 4
`define GPW_OS_IRQ_BIT 0
`define GPW_DOG_IRQ_BIT 4
`define GPW_OS_SEL_LO 0
`define GPW_DOG_SEL_LO 4

// ==========================================================
// reset values
`define GPW_LIMIT_RESET 8'hff
`define GPW_SEL_RESET 2'h0
`define GPW_BYTE_ZERO 8'h00
`define GPW_COUNT_ZERO 8'h00

// ==========================================================
// tick select codes
`define GPW_OS_SEL_32K 2'h0
`define GPW_OS_SEL_1K 2'h1
`define GPW_OS_SEL_1HZ 2'h2
`define GPW_DOG_SEL_8HZ 2'h0
`define GPW_DOG_SEL_1HZ 2'h1
`define GPW_DOG_SEL_HALF 2'h2

// ==========================================================
// prescaler masks on the 32.768 kHz strobe
`define GPW_DIV_1K 16'h001f
`define GPW_DIV_8HZ 16'h0fff
`define GPW_DIV_1HZ 16'h7fff
`define GPW_DIV_HALF 16'hffff
`define GPW_PRE_ZERO 16'h0000
`define GPW_PRE_ONE 16'h0001
`define GPW_SEC_LAST 6'h3b
`define GPW_SEC_ZERO 6'h00
`define GPW_SEC_ONE 6'h01

`endif

// ### core/gpw_pkg.sv
// types shared by the timer block
package gpw_pkg;
  typedef logic [7:0] gpw_byte_type;
  typedef logic [1:0] gpw_sel_type;
  typedef struct packed {
    logic run;
    logic [7:0] count;
    logic expired;
  } gpw_cnt_type;
endpackage : gpw_pkg

// ### core/gpw_tick_if.sv
// tick strobes and their selects between the timebase and the timers
`timescale 1ns/100ps
interface gpw_tick_if;
  logic gate_on;
  logic [1:0] os_sel;
  logic [1:0] dog_sel;
  logic os_tick;
  logic dog_tick;
  modport gen (input gate_on, input os_sel, input dog_sel, output os_tick, output dog_tick);
  modport user (output gate_on, output os_sel, output dog_sel, input os_tick, input dog_tick);
endinterface : gpw_tick_if

// ### core/gpw_tickgen.sv
// timebase: divides the 32.768 kHz strobe into the selectable tick rates
`timescale 1ns/100ps
`include "gpw_regs.svh"
module gpw_tickgen
  import gpw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic rtc_tick_32k,
  gpw_tick_if.gen tk
);
  logic [15:0] pre_q, pre_d;
  logic [5:0] sec_q, sec_d;
  logic os_tick_q, os_tick_d;
  logic dog_tick_q, dog_tick_d;
  logic step;
  logic hit_1k, hit_8, hit_1, hit_half, hit_min;

  // ==========================================================
  // prescaler
  always_comb begin
    // prescaler frozen while gated, so the phase survives a gate-off
    step = rtc_tick_32k & tk.gate_on;
    hit_1k = step && ((pre_q & `GPW_DIV_1K) == `GPW_DIV_1K);
    hit_8 = step && ((pre_q & `GPW_DIV_8HZ) == `GPW_DIV_8HZ);
    hit_1 = step && ((pre_q & `GPW_DIV_1HZ) == `GPW_DIV_1HZ);
    hit_half = step && (pre_q == `GPW_DIV_HALF);
    hit_min = hit_1 && (sec_q == `GPW_SEC_LAST);
    pre_d = pre_q;
    sec_d = sec_q;
    if (step) begin
      pre_d = pre_q + `GPW_PRE_ONE;
    end
    if (hit_1) begin
      sec_d = hit_min ? `GPW_SEC_ZERO : sec_q + `GPW_SEC_ONE;
    end
    case (tk.os_sel)
      `GPW_OS_SEL_32K: os_tick_d = step;
      `GPW_OS_SEL_1K: os_tick_d = hit_1k;
      `GPW_OS_SEL_1HZ: os_tick_d = hit_1;
      default: os_tick_d = hit_min;
    endcase
    case (tk.dog_sel)
      `GPW_DOG_SEL_8HZ: dog_tick_d = hit_8;
      `GPW_DOG_SEL_1HZ: dog_tick_d = hit_1;
      `GPW_DOG_SEL_HALF: dog_tick_d = hit_half;
      default: dog_tick_d = hit_min;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_q <= `GPW_PRE_ZERO;
      sec_q <= `GPW_SEC_ZERO;
      os_tick_q <= 1'b0;
      dog_tick_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      sec_q <= sec_d;
      os_tick_q <= os_tick_d;
      dog_tick_q <= dog_tick_d;
    end
  end

  assign tk.os_tick = os_tick_q;
  assign tk.dog_tick = dog_tick_q;
endmodule : gpw_tickgen

// ### bench/gpw_timers_chk.sv
// port checker of the timer block
`timescale 1ns/100ps
module gpw_timers_chk #(
  parameter int ADDR_W = 8
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic rtc_tick_32k,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic timer_irq,
  input wire logic oneshot_running,
  input wire logic dog_running
);
  // ====
  // decoded writes
  logic w_os, w_dog, w_clr;
  assign w_os = reg_wr && (reg_addr == ADDR_W'(8'ha1));
  assign w_dog = reg_wr && (reg_addr == ADDR_W'(8'ha0));
  // irq may only drop through a flag clear or a mask write
  assign w_clr = reg_wr && (reg_addr == ADDR_W'(8'ha2) || reg_addr == ADDR_W'(8'ha6));
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ====
  // assertions
  a_os_start: assert property (w_os && reg_wdata[0] && !oneshot_running |=> oneshot_running)
    else $error("one-shot did not start");
  a_os_stop: assert property (w_os && !reg_wdata[0] |=> !oneshot_running)
    else $error("one-shot did not stop");
  a_dog_start: assert property (w_dog && reg_wdata[0] && !dog_running |=> dog_running)
    else $error("watchdog did not start");
  a_dog_stop: assert property (w_dog && !reg_wdata[0] |=> !dog_running)
    else $error("watchdog did not stop");
  a_kick_reads0: assert property (reg_rd && reg_addr == ADDR_W'(8'ha0) |=> reg_rdata[4] == 1'b0)
    else $error("kick bit read as one");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_irq_drop: assert property ($fell(timer_irq) |-> $past(w_clr) || $past(w_clr, 2))
    else $error("irq dropped without clear");
  a_irq_cause: assert property ($rose(timer_irq) |->
    $fell(oneshot_running) || $fell(dog_running) || $past(w_clr) || $past(w_clr, 2))
    else $error("irq rose without expiry");
endmodule : gpw_timers_chk

bind gpw_timers gpw_timers_chk #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .rst(rst), .rtc_tick_32k(rtc_tick_32k),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .timer_irq(timer_irq), .oneshot_running(oneshot_running), .dog_running(dog_running));

// ### bench/gpw_timers_test.sv
// self-checking bench of the timer block
`timescale 1ns/100ps
module gpw_timers_test;
  import gpw_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rtc_tick_32k = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  gpw_byte_type reg_wdata = 8'h00;
  gpw_byte_type reg_rdata;
  logic timer_irq, oneshot_running, dog_running;
  int err_total = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h6e2c5359;
  // register image and writable masks
  int mdl [int] = '{8'ha3:8'hff, 8'ha4:8'hff};
  int msk [int] = '{8'h3a:8'h01, 8'ha0:8'h01, 8'ha1:8'h01, 8'ha3:8'hff, 8'ha4:8'hff, 8'ha5:8'h33, 8'ha6:8'h11};
  logic [7:0] all_q [$] = '{8'h3a, 8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7};
  logic [7:0] cfg_q [$] = '{8'h3a, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7};
  int n1, n2, lim;

  always #12.5 clk = ~clk;

  gpw_timers dut (.clk(clk), .rst(rst), .rtc_tick_32k(rtc_tick_32k), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .timer_irq(timer_irq),
    .oneshot_running(oneshot_running), .dog_running(dog_running));

  // ====
  // helpers
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    checks_done++;
    if (got !== ex) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // flags clear on ones only
    if (a == 8'ha2 && mdl.exists(a)) mdl[a] = mdl[a] & ~d;
    else if (msk.exists(a)) mdl[a] = d & msk[a];
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), mdl.exists(a) ? 8'(mdl[a]) : 8'h00, reg_rdata);
  endtask : rd

  // bounded wait for a timer to stop
  task automatic wait_stop(input bit dog, input int bound, output int n);
    n = 0;
    while ((dog ? dog_running : oneshot_running) !== 1'b0) begin
      @(posedge clk);
      #1;
      n++;
      if (n > bound) begin
        chk("stop wait", 8'h00, 8'h01);
        tally_and_finish();
      end
    end
  endtask : wait_stop

  task automatic irq_is(input logic v);
    repeat (2) @(posedge clk);
    #1;
    chk("irq", {7'h00, v}, {7'h00, timer_irq});
  endtask : irq_is

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // ====
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (all_q[i]) rd(all_q[i]);
    foreach (cfg_q[i]) wr(cfg_q[i], 8'(rnd()));
    foreach (cfg_q[i]) rd(cfg_q[i]);
    wr(8'h3a, 8'h01);
    wr(8'ha5, 8'h00);
    wr(8'ha0, 8'h10);
    rd(8'ha0);
    chk("dog idle", 8'h00, {7'h00, dog_running});
    // one-shot with random limit, repeated
    lim = 1 + (rnd() & 7);
    wr(8'ha3, 8'(lim));
    wr(8'ha6, 8'h11);
    wr(8'ha1, 8'h01);
    chk("os run", 8'h01, {7'h00, oneshot_running});
    wait_stop(0, 300, n1);
    chk("os span", 8'h01, {7'h00, n1 >= lim && n1 <= lim + 3});
    mdl[8'ha1] = 0;
    mdl[8'ha2] = 1;
    rd(8'ha1);
    rd(8'ha2);
    irq_is(1'b1);
    wr(8'ha2, 8'h00);
    rd(8'ha2);
    wr(8'ha2, 8'h01);
    irq_is(1'b0);
    wr(8'ha1, 8'h01);
    wait_stop(0, 300, n2);
    chk("os repeat", 8'(n1), 8'(n2));
    wr(8'ha2, 8'h01);
    // masked interrupt
    wr(8'ha6, 8'h00);
    wr(8'ha1, 8'h01);
    wait_stop(0, 300, n1);
    mdl[8'ha2] = 1;
    rd(8'ha2);
    irq_is(1'b0);
    wr(8'ha6, 8'h01);
    irq_is(1'b1);
    wr(8'ha2, 8'h01);
    // disable mid count clears the counter
    wr(8'ha3, 8'hff);
    wr(8'ha1, 8'h01);
    repeat (20) @(posedge clk);
    wr(8'ha1, 8'h00);
    chk("os stop", 8'h00, {7'h00, oneshot_running});
    wr(8'ha1, 8'h01);
    wait_stop(0, 400, n1);
    chk("os cleared", 8'h01, {7'h00, n1 >= 255});
    wr(8'ha2, 8'h01);
    // gate off freezes counting
    wr(8'ha3, 8'h04);
    wr(8'h3a, 8'h00);
    wr(8'ha1, 8'h01);
    repeat (40) @(posedge clk);
    #1;
    chk("gated", 8'h01, {7'h00, oneshot_running});
    rd(8'ha3);
    wr(8'h3a, 8'h01);
    wait_stop(0, 50, n1);
    wr(8'ha2, 8'h01);
    // slower one-shot rate
    wr(8'ha5, 8'h01);
    wr(8'ha3, 8'h02);
    wr(8'ha1, 8'h01);
    wait_stop(0, 120, n1);
    chk("os 1k rate", 8'h01, {7'h00, n1 >= 33});
    wr(8'ha2, 8'h01);
    mdl[8'ha1] = 0;
    // watchdog kick, expiry and stop
    wr(8'ha4, 8'h02);
    wr(8'ha0, 8'h01);
    chk("dog run", 8'h01, {7'h00, dog_running});
    // kicks closer than one 8 Hz tick keep the count below two; without them it would expire
    repeat (2) begin
      repeat (3000) @(posedge clk);
      wr(8'ha0, 8'h11);
    end
    repeat (3000) @(posedge clk);
    #1;
    chk("dog kicked", 8'h01, {7'h00, dog_running});
    rd(8'ha2);
    wait_stop(1, 9000, n1);
    chk("dog rate", 8'h01, {7'h00, n1 >= 1000 && n1 <= 5300});
    mdl[8'ha2] = 8'h10;
    mdl[8'ha0] = 0;
    rd(8'ha2);
    rd(8'ha0);
    irq_is(1'b0);
    wr(8'ha6, 8'h10);
    irq_is(1'b1);
    wr(8'ha2, 8'h10);
    irq_is(1'b0);
    wr(8'ha0, 8'h01);
    repeat (10) @(posedge clk);
    wr(8'ha0, 8'h00);
    chk("dog stop", 8'h00, {7'h00, dog_running});
    tally_and_finish();
  end
endmodule : gpw_timers_test
